//--- include/adcoi_pkg.sv
package adcoi_pkg;
    localparam int ADCOI_DATA_W = 10;
    localparam int ADCOI_PIPE_LATENCY = 5;
    localparam logic [7:0] ADCOI_ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADCOI_ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADCOI_ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADCOI_ADDR_IRQ_CLEAR = 8'h0c;
    localparam logic [7:0] ADCOI_ADDR_IRQ_ENABLE = 8'h10;
    localparam int ADCOI_CTRL_OVR_BIT = 0;
    localparam int ADCOI_CTRL_MODE_LSB = 1;
    localparam int ADCOI_CTRL_FMT_LSB = 3;
    localparam logic [4:0] ADCOI_CTRL_RESET = 5'h00;
    localparam int ADCOI_ST_MODE_LSB = 0;
    localparam int ADCOI_ST_FMT_LSB = 2;
    localparam int ADCOI_ST_TWOS_BIT = 4;
    localparam int ADCOI_ST_DCS_BIT = 5;
    localparam int ADCOI_ST_PWR_LSB = 6;
    localparam int ADCOI_ST_COUNT_LSB = 16;
    localparam int ADCOI_IRQ_W = 3;
    localparam int ADCOI_IRQ_CONV_BIT = 0;
    localparam int ADCOI_IRQ_RANGE_BIT = 1;
    localparam int ADCOI_IRQ_PWR_BIT = 2;
    localparam logic [2:0] ADCOI_IRQ_RESET = 3'h0;
    localparam logic [1:0] ADCOI_STRAP_0V = 2'h0;
    localparam logic [1:0] ADCOI_STRAP_THIRD = 2'h1;
    localparam logic [1:0] ADCOI_STRAP_TWO_THIRDS = 2'h2;
    localparam logic [1:0] ADCOI_STRAP_FULL = 2'h3;
    typedef enum logic [1:0] {
        ADCOI_OUT_FULL_RATE,
        ADCOI_OUT_DEMUX_SIMUL,
        ADCOI_OUT_DEMUX_INTERLEAVE,
        ADCOI_OUT_DIFFERENTIAL
    } adcoi_out_mode_t;
    typedef enum logic [1:0] {
        ADCOI_PWR_ACTIVE,
        ADCOI_PWR_OUTPUTS_OFF,
        ADCOI_PWR_NAP,
        ADCOI_PWR_SLEEP
    } adcoi_pwr_t;
endpackage : adcoi_pkg

//--- verilog/adcoi_sync.sv
`timescale 1ns/1ps
module adcoi_sync #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : adcoi_sync

//--- verilog/adcoi_top.sv
`timescale 1ns/1ps
// What this block does
// RULE1: A conversion starts on each rising encode_p edge, i.e. falling encode_n edge.
// RULE2: Power-down low and output enable low: convert and drive the outputs, bus B data and overflow in demux modes only.
// RULE3: Power-down low, output enable high: keep converting, outputs high impedance.
// RULE4: Power-down high, output enable low: nap, outputs high impedance.
// RULE5: Power-down high, output enable high: sleep, outputs high impedance.
// RULE6: Ten-bit bus B, bit 9 is MSB, high impedance in full-rate mode.
// RULE7: Bus B overflow flags an out-of-range sample, high impedance at full rate.
// RULE8: Interleaved demux: receiver latches bus B on falling bus B valid clock.
// RULE9: Simultaneous demux: receiver latches bus B on rising bus B valid clock.
// RULE10: Bus B valid clock stays driven in full-rate mode.
// RULE11: Receiver latches bus A on the falling edge of bus A valid clock.
// RULE12: Ten-bit bus A, bit 9 is MSB, active in every single-ended mode.
// RULE13: Bus A overflow is high when its sample came from an out-of-range input.
// RULE14: Four-level strap picks full rate, demux simultaneous, demux interleaved, differential.
// RULE15: Four-level strap picks code format and duty cycle stabilizer setting.
// RULE16: In two's complement, near-zero input toggles between all zeros and all ones.
// RULE17: In demux modes results alternate between buses, each at half encode rate.
// RULE18: Offset binary is two's complement with the MSB inverted.
module adcoi_top
    import adcoi_pkg::*;
#(
    parameter int DATA_W = ADCOI_DATA_W,
    parameter int PIPE_LATENCY = ADCOI_PIPE_LATENCY
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic encode_p,
    input wire logic encode_n,
    input wire logic [DATA_W-1:0] core_code,
    input wire logic core_out_of_range,
    input wire logic power_down_select,
    input wire logic output_enable_n,
    input wire logic [1:0] output_mode_strap,
    input wire logic [1:0] format_strap,
    output logic [DATA_W-1:0] bus_a_data,
    output logic bus_a_data_oe,
    output logic bus_a_overflow,
    output logic bus_a_overflow_oe,
    output logic bus_a_valid_clock,
    output logic bus_a_valid_clock_oe,
    output logic [DATA_W-1:0] bus_b_data,
    output logic bus_b_data_oe,
    output logic bus_b_overflow,
    output logic bus_b_overflow_oe,
    output logic bus_b_valid_clock,
    output logic bus_b_valid_clock_oe
);
    localparam int SYNC_W = DATA_W + 9;

    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] sync_in;
    logic enc_p_s;
    logic enc_n_s;
    logic [DATA_W-1:0] code_s;
    logic range_s;
    logic pds_s;
    logic oen_s;
    logic [1:0] mode_strap_s;
    logic [1:0] fmt_strap_s;

    logic enc_lvl;
    logic enc_prev_q;
    logic enc_rise;
    logic enc_fall;

    logic [4:0] ctrl_q;
    logic [ADCOI_IRQ_W-1:0] irq_status_q;
    logic [ADCOI_IRQ_W-1:0] irq_enable_q;
    logic [ADCOI_IRQ_W-1:0] irq_event;
    logic [ADCOI_IRQ_W-1:0] irq_clear;
    logic [15:0] conv_count_q;

    adcoi_out_mode_t out_mode;
    adcoi_pwr_t pwr_state;
    adcoi_pwr_t pwr_prev_q;
    logic [1:0] fmt_sel;
    logic twos_fmt;
    logic dcs_on;
    logic converting;
    logic drive_en;
    logic demux;

    logic [DATA_W-1:0] pipe_code_q [PIPE_LATENCY];
    logic pipe_range_q [PIPE_LATENCY];
    logic [DATA_W-1:0] out_code;
    logic out_range;
    logic phase_q;
    logic [DATA_W-1:0] hold_code_q;
    logic hold_range_q;
    logic [DATA_W-1:0] a_data_q;
    logic a_range_q;
    logic [DATA_W-1:0] b_data_q;
    logic b_range_q;
    logic clk_a_q;
    logic clk_b_q;

    logic wr_en;
    logic rd_en;
    logic addr_ok;

    assign raw_in = {encode_p, encode_n, core_out_of_range, power_down_select,
                     output_enable_n, output_mode_strap, format_strap, core_code};

    adcoi_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(raw_in),
        .sync_out(sync_in)
    );

    assign enc_p_s = sync_in[SYNC_W-1];
    assign enc_n_s = sync_in[SYNC_W-2];
    assign range_s = sync_in[SYNC_W-3];
    assign pds_s = sync_in[SYNC_W-4];
    assign oen_s = sync_in[SYNC_W-5];
    assign mode_strap_s = sync_in[DATA_W+3:DATA_W+2];
    assign fmt_strap_s = sync_in[DATA_W+1:DATA_W];
    assign code_s = sync_in[DATA_W-1:0];

    // Encode is high while the true input is above its complement.
    assign enc_lvl = enc_p_s & ~enc_n_s;
    assign enc_rise = enc_lvl & ~enc_prev_q; // see RULE1
    assign enc_fall = ~enc_lvl & enc_prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enc_prev_q <= 1'b0;
        end else begin
            enc_prev_q <= enc_lvl;
        end
    end

    // Strap decode, with an optional software override.
    always_comb begin
        logic [1:0] msel;
        msel = ctrl_q[ADCOI_CTRL_OVR_BIT] ? ctrl_q[ADCOI_CTRL_MODE_LSB +: 2] : mode_strap_s;
        fmt_sel = ctrl_q[ADCOI_CTRL_OVR_BIT] ? ctrl_q[ADCOI_CTRL_FMT_LSB +: 2] : fmt_strap_s;
        case (msel) // see RULE14
            ADCOI_STRAP_0V: out_mode = ADCOI_OUT_FULL_RATE;
            ADCOI_STRAP_THIRD: out_mode = ADCOI_OUT_DEMUX_SIMUL;
            ADCOI_STRAP_TWO_THIRDS: out_mode = ADCOI_OUT_DEMUX_INTERLEAVE;
            default: out_mode = ADCOI_OUT_DIFFERENTIAL;
        endcase
        case (fmt_sel) // see RULE15
            ADCOI_STRAP_0V: begin
                twos_fmt = 1'b0;
                dcs_on = 1'b0;
            end
            ADCOI_STRAP_THIRD: begin
                twos_fmt = 1'b0;
                dcs_on = 1'b1;
            end
            ADCOI_STRAP_TWO_THIRDS: begin
                twos_fmt = 1'b1;
                dcs_on = 1'b1;
            end
            default: begin
                twos_fmt = 1'b1;
                dcs_on = 1'b0;
            end
        endcase
    end

    // Power state from power-down select and output enable.
    always_comb begin
        case ({pds_s, oen_s})
            2'b00: pwr_state = ADCOI_PWR_ACTIVE; // see RULE2
            2'b01: pwr_state = ADCOI_PWR_OUTPUTS_OFF; // see RULE3
            2'b10: pwr_state = ADCOI_PWR_NAP; // see RULE4
            default: pwr_state = ADCOI_PWR_SLEEP; // see RULE5
        endcase
    end

    assign converting = ~pds_s; // see RULE3
    assign drive_en = ~pds_s & ~oen_s; // see RULE2
    assign demux = (out_mode == ADCOI_OUT_DEMUX_SIMUL) ||
                   (out_mode == ADCOI_OUT_DEMUX_INTERLEAVE);

    // Conversion pipeline; the core delivers two's complement codes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < PIPE_LATENCY; i++) begin
                pipe_code_q[i] <= '0;
                pipe_range_q[i] <= 1'b0;
            end
        end else if (enc_rise && converting) begin // see RULE1
            pipe_code_q[0] <= code_s;
            pipe_range_q[0] <= range_s;
            for (int i = 1; i < PIPE_LATENCY; i++) begin
                pipe_code_q[i] <= pipe_code_q[i-1];
                pipe_range_q[i] <= pipe_range_q[i-1];
            end
        end
    end

    // Offset binary flips the MSB, so mid-scale reads as 10'h200 or 10'h1ff, not all zeros or all ones.
    always_comb begin
        out_code = pipe_code_q[PIPE_LATENCY-1]; // see RULE16
        if (!twos_fmt) begin
            out_code[DATA_W-1] = ~pipe_code_q[PIPE_LATENCY-1][DATA_W-1]; // see RULE18
        end
        out_range = pipe_range_q[PIPE_LATENCY-1];
    end

    // Output buses and their valid clocks.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= 1'b0;
            hold_code_q <= '0;
            hold_range_q <= 1'b0;
            a_data_q <= '0;
            a_range_q <= 1'b0;
            b_data_q <= '0;
            b_range_q <= 1'b0;
            clk_a_q <= 1'b0;
            clk_b_q <= 1'b0;
        end else if (converting && enc_rise) begin
            phase_q <= demux ? ~phase_q : 1'b0;
            case (out_mode)
                ADCOI_OUT_DEMUX_INTERLEAVE: begin
                    if (!phase_q) begin
                        a_data_q <= out_code; // see RULE17
                        a_range_q <= out_range; // see RULE13
                        clk_a_q <= 1'b1;
                        clk_b_q <= 1'b0; // see RULE8
                    end else begin
                        b_data_q <= out_code; // see RULE17
                        b_range_q <= out_range; // see RULE7
                        clk_a_q <= 1'b0; // see RULE11
                        clk_b_q <= 1'b1;
                    end
                end
                ADCOI_OUT_DEMUX_SIMUL: begin
                    if (!phase_q) begin
                        hold_code_q <= out_code;
                        hold_range_q <= out_range;
                        clk_a_q <= 1'b0; // see RULE11
                        clk_b_q <= 1'b1; // see RULE9
                    end else begin
                        a_data_q <= hold_code_q; // see RULE17
                        a_range_q <= hold_range_q; // see RULE13
                        b_data_q <= out_code;
                        b_range_q <= out_range; // see RULE7
                        clk_a_q <= 1'b1;
                        clk_b_q <= 1'b0;
                    end
                end
                default: begin
                    a_data_q <= out_code; // see RULE12
                    a_range_q <= out_range; // see RULE13
                    clk_a_q <= 1'b1;
                    clk_b_q <= 1'b1; // see RULE10
                end
            endcase
        end else if (converting && enc_fall && !demux) begin
            clk_a_q <= 1'b0; // see RULE11
            clk_b_q <= 1'b0; // see RULE10
        end
    end

    assign bus_a_data = a_data_q;
    assign bus_a_overflow = a_range_q;
    assign bus_a_valid_clock = clk_a_q;
    assign bus_b_data = b_data_q;
    assign bus_b_overflow = b_range_q;
    assign bus_b_valid_clock = clk_b_q;
    assign bus_a_data_oe = drive_en; // see RULE12
    assign bus_a_overflow_oe = drive_en;
    assign bus_a_valid_clock_oe = drive_en;
    assign bus_b_data_oe = drive_en & demux; // see RULE6
    assign bus_b_overflow_oe = drive_en & demux; // see RULE7
    assign bus_b_valid_clock_oe = drive_en; // see RULE10

    // Conversion counter and power state history.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_count_q <= 16'h0000;
        end else if (enc_rise && converting) begin
            conv_count_q <= conv_count_q + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_prev_q <= ADCOI_PWR_ACTIVE;
        end else begin
            pwr_prev_q <= pwr_state;
        end
    end

    // APB slave with no wait states.
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign addr_ok = (paddr == ADCOI_ADDR_CTRL) || (paddr == ADCOI_ADDR_STATUS) ||
                     (paddr == ADCOI_ADDR_IRQ_STATUS) || (paddr == ADCOI_ADDR_IRQ_CLEAR) ||
                     (paddr == ADCOI_ADDR_IRQ_ENABLE);
    assign pslverr = psel & penable & ~addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= ADCOI_CTRL_RESET;
        end else if (wr_en && paddr == ADCOI_ADDR_CTRL && pstrb[0]) begin
            ctrl_q <= pwdata[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable_q <= ADCOI_IRQ_RESET;
        end else if (wr_en && paddr == ADCOI_ADDR_IRQ_ENABLE && pstrb[0]) begin
            irq_enable_q <= pwdata[ADCOI_IRQ_W-1:0];
        end
    end

    assign irq_event[ADCOI_IRQ_CONV_BIT] = enc_rise & converting;
    assign irq_event[ADCOI_IRQ_RANGE_BIT] = enc_rise & converting & out_range;
    assign irq_event[ADCOI_IRQ_PWR_BIT] = (pwr_state != pwr_prev_q);
    assign irq_clear = (wr_en && paddr == ADCOI_ADDR_IRQ_CLEAR && pstrb[0]) ?
                       pwdata[ADCOI_IRQ_W-1:0] : ADCOI_IRQ_RESET;

    // A new event outranks a clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_q <= ADCOI_IRQ_RESET;
        end else begin
            irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
        end
    end

    assign irq = |(irq_status_q & irq_enable_q);

    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                ADCOI_ADDR_CTRL: prdata[4:0] = ctrl_q;
                ADCOI_ADDR_STATUS: begin
                    prdata[ADCOI_ST_MODE_LSB +: 2] = out_mode;
                    prdata[ADCOI_ST_FMT_LSB +: 2] = fmt_sel;
                    prdata[ADCOI_ST_TWOS_BIT] = twos_fmt;
                    prdata[ADCOI_ST_DCS_BIT] = dcs_on;
                    prdata[ADCOI_ST_PWR_LSB +: 2] = pwr_state;
                    prdata[ADCOI_ST_COUNT_LSB +: 16] = conv_count_q;
                end
                ADCOI_ADDR_IRQ_STATUS: prdata[ADCOI_IRQ_W-1:0] = irq_status_q;
                ADCOI_ADDR_IRQ_ENABLE: prdata[ADCOI_IRQ_W-1:0] = irq_enable_q;
                default: prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule : adcoi_top

//--- verif/adcoi_properties.sv
`timescale 1ns/1ps
module adcoi_properties
    import adcoi_pkg::*;
#(
    parameter int DATA_W = ADCOI_DATA_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic encode_p,
    input wire logic power_down_select,
    input wire logic output_enable_n,
    input wire logic [1:0] output_mode_strap,
    input wire logic [DATA_W-1:0] bus_a_data,
    input wire logic bus_a_data_oe,
    input wire logic bus_a_overflow,
    input wire logic bus_a_overflow_oe,
    input wire logic bus_a_valid_clock,
    input wire logic bus_a_valid_clock_oe,
    input wire logic [DATA_W-1:0] bus_b_data,
    input wire logic bus_b_data_oe,
    input wire logic bus_b_overflow_oe,
    input wire logic bus_b_valid_clock,
    input wire logic bus_b_valid_clock_oe
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_OE_OFF: assert property (
        output_enable_n[*4] |-> !bus_a_data_oe && !bus_a_valid_clock_oe && !bus_b_valid_clock_oe)
        else $error("outputs driven with output enable off");
    AST_PD_OFF: assert property (
        power_down_select[*4] |-> !bus_a_data_oe && !bus_a_overflow_oe && !bus_a_valid_clock_oe)
        else $error("outputs driven while powered down");
    AST_DRIVE: assert property (
        (!power_down_select && !output_enable_n)[*4] |-> bus_a_data_oe && bus_a_overflow_oe
        && bus_a_valid_clock_oe && bus_b_valid_clock_oe)
        else $error("outputs not driven in normal operation");
    AST_B_HIDDEN: assert property (
        (output_mode_strap == ADCOI_STRAP_0V)[*4] |-> !bus_b_data_oe && !bus_b_overflow_oe)
        else $error("bus b driven at full rate");
    AST_B_DRIVE: assert property (
        (!power_down_select && !output_enable_n && (output_mode_strap == ADCOI_STRAP_THIRD
        || output_mode_strap == ADCOI_STRAP_TWO_THIRDS))[*4] |-> bus_b_data_oe
        && bus_b_overflow_oe)
        else $error("bus b not driven in demux mode");
    AST_B_CLK: assert property (
        (output_mode_strap == ADCOI_STRAP_0V)[*4] |-> bus_b_valid_clock == bus_a_valid_clock)
        else $error("bus b clock not following bus a clock");
    AST_A_UPDATE: assert property (
        $changed(bus_a_data) || $changed(bus_a_overflow) |-> $rose(bus_a_valid_clock))
        else $error("bus a changed without a rising valid clock");
    AST_B_INTER: assert property (
        (output_mode_strap == ADCOI_STRAP_TWO_THIRDS)[*4] ##0 $changed(bus_b_data)
        |-> $rose(bus_b_valid_clock) && $fell(bus_a_valid_clock))
        else $error("interleaved bus b update off its clock");
    AST_B_SIMUL: assert property (
        (output_mode_strap == ADCOI_STRAP_THIRD)[*4] ##0 $changed(bus_b_data)
        |-> $fell(bus_b_valid_clock) && $rose(bus_a_valid_clock))
        else $error("simultaneous bus b update off its clock");
    AST_ENCODE: assert property (
        (!power_down_select && output_mode_strap == ADCOI_STRAP_0V)[*4] ##0 $rose(encode_p)
        |-> ##[2:5] $rose(bus_a_valid_clock))
        else $error("encode rise gave no conversion");
    COV_A: cover property ($fell(bus_a_valid_clock) && bus_a_data_oe);
    COV_B: cover property ($rose(bus_b_valid_clock) && bus_b_data_oe);
    COV_PD: cover property (power_down_select[*4]);
endmodule : adcoi_properties

bind adcoi_top adcoi_properties #(.DATA_W(DATA_W)) u_adcoi_properties (
    .pclk(pclk),
    .presetn(presetn),
    .encode_p(encode_p),
    .power_down_select(power_down_select),
    .output_enable_n(output_enable_n),
    .output_mode_strap(output_mode_strap),
    .bus_a_data(bus_a_data),
    .bus_a_data_oe(bus_a_data_oe),
    .bus_a_overflow(bus_a_overflow),
    .bus_a_overflow_oe(bus_a_overflow_oe),
    .bus_a_valid_clock(bus_a_valid_clock),
    .bus_a_valid_clock_oe(bus_a_valid_clock_oe),
    .bus_b_data(bus_b_data),
    .bus_b_data_oe(bus_b_data_oe),
    .bus_b_overflow_oe(bus_b_overflow_oe),
    .bus_b_valid_clock(bus_b_valid_clock),
    .bus_b_valid_clock_oe(bus_b_valid_clock_oe)
);

//--- verif/adcoi_rx.sv
`timescale 1ns/1ps
module adcoi_rx
    import adcoi_pkg::*;
(
    input wire logic pclk,
    input wire logic [1:0] mode,
    input wire logic [9:0] a_data,
    input wire logic a_ovf,
    input wire logic a_clk,
    input wire logic a_oe,
    input wire logic [9:0] b_data,
    input wire logic b_ovf,
    input wire logic b_clk,
    input wire logic b_oe,
    output logic a_got,
    output logic b_got,
    output logic [10:0] a_word,
    output logic [10:0] b_word
);
    logic a_clk_q = 1'b0;
    logic b_clk_q = 1'b0;
    always @(posedge pclk) begin
        a_clk_q <= a_clk;
        b_clk_q <= b_clk;
        a_word <= {a_ovf, a_data};
        b_word <= {b_ovf, b_data};
        a_got <= a_oe && a_clk_q && !a_clk;
        b_got <= b_oe && (mode == ADCOI_STRAP_TWO_THIRDS ? b_clk_q && !b_clk :
            mode == ADCOI_STRAP_THIRD && !b_clk_q && b_clk);
    end
endmodule : adcoi_rx

//--- verif/adcoi_top_tb.sv
`timescale 1ns/1ps
module adcoi_top_tb
    import adcoi_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, wv;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, irq, er, tog;
    logic encode_p = 1'b0, encode_n = 1'b1, core_out_of_range = 1'b0;
    logic power_down_select = 1'b0, output_enable_n = 1'b0;
    logic [9:0] core_code = 10'h000, bus_a_data, bus_b_data;
    logic [1:0] output_mode_strap = 2'h0, format_strap = 2'h0;
    logic bus_a_data_oe, bus_a_overflow, bus_a_overflow_oe, bus_a_valid_clock;
    logic bus_a_valid_clock_oe, bus_b_data_oe, bus_b_overflow, bus_b_overflow_oe;
    logic bus_b_valid_clock, bus_b_valid_clock_oe, rx_a_got, rx_b_got;
    logic [10:0] rx_a_word, rx_b_word;
    logic [10:0] smp [0:511];
    int n_errors = 0, check_count = 0, rise_cnt = 0, seed = 41;

    adcoi_top u_adcoi_top (.*);
    adcoi_rx u_adcoi_rx (.pclk(pclk), .mode(output_mode_strap), .a_data(bus_a_data),
        .a_ovf(bus_a_overflow), .a_clk(bus_a_valid_clock), .a_oe(bus_a_data_oe),
        .b_data(bus_b_data), .b_ovf(bus_b_overflow), .b_clk(bus_b_valid_clock),
        .b_oe(bus_b_data_oe), .a_got(rx_a_got), .b_got(rx_b_got), .a_word(rx_a_word),
        .b_word(rx_b_word));

    always #5 pclk = ~pclk;

    initial begin
        #2.3;
        forever begin
            #62.5;
            encode_p = ~encode_p;
            encode_n = ~encode_p;
            if (encode_p && presetn && !power_down_select) begin
                rise_cnt++;
                smp[rise_cnt] = {core_out_of_range, core_code ^ (format_strap[1] ? 10'h0 : 10'h200)};
            end
        end
    end

    always @(negedge encode_p) begin
        @(posedge pclk);
        core_code <= tog ? {10{core_code == 10'h000}} : 10'($random(seed));
        core_out_of_range <= ($random(seed) & 3) == 0;
    end

    always @(posedge pclk) begin
        if (rx_a_got === 1'b1) take(1'b1, rx_a_word);
        if (rx_b_got === 1'b1) take(1'b0, rx_b_word);
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task take(input logic is_a, input logic [10:0] w);
        int idx;
        idx = rise_cnt - 5 - int'(output_mode_strap inside {2'h1, 2'h2});
        idx = idx - int'(output_mode_strap == ADCOI_STRAP_THIRD && is_a);
        if (idx > 0) chk(32'(w), 32'(smp[idx]));
    endtask : take

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task seg(input logic [1:0] m, input logic [1:0] f, input logic t);
        tog = t;
        @(negedge encode_p);
        @(posedge pclk);
        presetn <= 1'b0;
        rise_cnt = 0;
        output_mode_strap <= m;
        format_strap <= f;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, ADCOI_ADDR_STATUS, 32'h0);
        chk(32'(rd[7:0]), 32'({2'h0, (f == 2'h1 || f == 2'h2), f[1], f, m}));
        repeat (600) @(posedge pclk);
        @(negedge encode_p);
        apb(1'b0, ADCOI_ADDR_STATUS, 32'h0);
        chk(32'(rd[31:16]), rise_cnt);
    endtask : seg

    task wrap_up;
        if (n_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up

    initial begin
        tog = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        seg(ADCOI_STRAP_0V, ADCOI_STRAP_0V, 1'b0);
        apb(1'b0, ADCOI_ADDR_CTRL, 32'h0);
        chk(rd, 32'(ADCOI_CTRL_RESET));
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h0);
        chk(32'(er), 32'h1);
        wv = $random(seed) & 32'h1e;
        apb(1'b1, ADCOI_ADDR_CTRL, wv);
        apb(1'b0, ADCOI_ADDR_CTRL, 32'h0);
        chk(rd, wv);
        apb(1'b1, ADCOI_ADDR_CTRL, 32'h0);
        for (int i = 3; i >= 0; i--) begin
            @(negedge encode_p);
            repeat (3) @(posedge pclk);
            power_down_select <= i[1];
            output_enable_n <= i[0];
            repeat (100) @(posedge pclk);
            apb(1'b0, ADCOI_ADDR_STATUS, 32'h0);
            chk(32'(rd[7:6]), i);
            apb(1'b1, ADCOI_ADDR_IRQ_ENABLE, 32'(!i[0]));
            @(posedge pclk);
            chk(32'(irq), 32'(!i[0]));
            if (i == 2) begin
                apb(1'b1, ADCOI_ADDR_IRQ_CLEAR, 32'h7);
                @(posedge pclk);
                chk(32'(irq), 32'h0);
                apb(1'b0, ADCOI_ADDR_IRQ_STATUS, 32'h0);
                chk(rd, 32'h0);
            end
        end
        apb(1'b1, ADCOI_ADDR_CTRL, 32'h0000_000f);
        apb(1'b0, ADCOI_ADDR_STATUS, 32'h0);
        chk(32'(rd[7:0]), 32'h0000_0027);
        apb(1'b1, ADCOI_ADDR_CTRL, 32'h0);
        seg(ADCOI_STRAP_THIRD, ADCOI_STRAP_THIRD, 1'b0);
        seg(ADCOI_STRAP_TWO_THIRDS, ADCOI_STRAP_TWO_THIRDS, 1'b0);
        seg(ADCOI_STRAP_FULL, ADCOI_STRAP_FULL, 1'b0);
        seg(ADCOI_STRAP_0V, ADCOI_STRAP_FULL, 1'b1);
        wrap_up();
    end

    initial begin
        #200000;
        n_errors++;
        wrap_up();
    end
endmodule : adcoi_top_tb
